// >>> hw/asq_seq.sv
/*
  hardware-trigger scan sequencer, one-shot, four scan slots, with an
  AXI4-Lite register slave and a sticky/masked interrupt.
  assumes: hwTrigger and convRsp are synchronous to core_clk; the
  converter drops a conversion on abort and never answers it.
*/
`timescale 1ns/100ps
`include "asq_consts.svh"

module asq_seq (
  input  wire logic                  core_clk,
  input  wire logic                  arst_n,
  // axi4-lite slave
  input  wire logic [`ASQ_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [`ASQ_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // trigger and converter
  input  wire logic                  hwTrigger,
  output asq_pkg::asq_conv_req_s     convReq,
  input  wire asq_pkg::asq_conv_rsp_s convRsp,
  output logic                       converterPowered,
  output logic                       conversionDoneIrq,
  output logic                       irq
);
  import asq_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  asq_state_e  state;              // sequencer state
  logic        powerEnable;        // converter power enable
  logic        startBit;           // conversion start bit
  logic        waitMode;           // 1: wait trigger mode
  logic [31:0] chanSel;            // four slot channel fields
  logic [1:0]  slot;               // slot being converted
  logic [`ASQ_RES_W-1:0] result;   // last stored result
  logic [`ASQ_CH_W-1:0]  resChan;  // channel of last result
  logic        irqStat;            // sticky end-of-conversion
  logic        irqMask;            // 1 lets it reach irq

  // ----------------------------------------------------------------
  // axi write capture
  // ----------------------------------------------------------------
  logic                   awHeld;   // address taken, waiting
  logic                   wHeld;    // data taken, waiting
  logic [`ASQ_ADDR_W-1:0] awAddr;   // held write address
  logic [31:0]            wData;    // held write data
  logic [3:0]             wStrb;    // held byte enables
  logic                   wrFire;   // write commits this cycle
  logic                   wrMode;   // commit hits mode register
  logic                   wrChsel;  // commit hits channel select
  logic                   wrIrqSt;  // commit hits irq status
  logic                   wrIrqMk;  // commit hits irq mask
  logic                   wrMapped; // commit hits any register

  assign wrFire   = awHeld && wHeld && !s_axi_bvalid;
  assign wrMode   = wrFire && awAddr == `ASQ_OFS_MODE && wStrb[0];
  assign wrChsel  = wrFire && awAddr == `ASQ_OFS_CHSEL
                    && wStrb != 4'h0;
  assign wrIrqSt  = wrFire && awAddr == `ASQ_OFS_IRQST && wStrb[0];
  assign wrIrqMk  = wrFire && awAddr == `ASQ_OFS_IRQMSK && wStrb[0];
  assign wrMapped = awAddr == `ASQ_OFS_MODE
                    || awAddr == `ASQ_OFS_CHSEL
                    || awAddr == `ASQ_OFS_RESULT
                    || awAddr == `ASQ_OFS_STATUS
                    || awAddr == `ASQ_OFS_IRQST
                    || awAddr == `ASQ_OFS_IRQMSK;

  // address and data channels taken in either order
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddr        <= '0;
      wData         <= '0;
      wStrb         <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      // accept address when not already holding one
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= {s_axi_awaddr[`ASQ_ADDR_W-1:2], 2'b00};
      end else if (wrFire) begin
        awHeld <= 1'b0;
      end
      // accept data when not already holding it
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end else if (wrFire) begin
        wHeld <= 1'b0;
      end
      s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !wHeld && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // write response, slverr on unmapped address
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrMapped ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // axi read
  // ----------------------------------------------------------------
  logic [31:0] rdMux;   // register selected by read address
  logic        rdHit;   // read address is mapped

  always_comb begin
    rdMux = 32'h0000_0000;
    rdHit = 1'b1;
    case ({s_axi_araddr[`ASQ_ADDR_W-1:2], 2'b00})
      `ASQ_OFS_MODE: begin
        rdMux[`ASQ_BIT_POWER] = powerEnable;
        rdMux[`ASQ_BIT_START] = startBit;
        rdMux[`ASQ_BIT_WAIT]  = waitMode;
      end
      `ASQ_OFS_CHSEL: begin
        rdMux = chanSel;
      end
      `ASQ_OFS_RESULT: begin
        rdMux[`ASQ_RES_W-1:0] = result;
        rdMux[`ASQ_RES_CH_LSB +: `ASQ_CH_W] = resChan;
      end
      `ASQ_OFS_STATUS: begin
        rdMux[1:0] = state;
        rdMux[5:4] = slot;
        rdMux[8]   = converterPowered;
      end
      `ASQ_OFS_IRQST: begin
        rdMux[`ASQ_BIT_EOC] = irqStat;
      end
      `ASQ_OFS_IRQMSK: begin
        rdMux[`ASQ_BIT_EOC] = irqMask;
      end
      default: begin
        rdHit = 1'b0;
      end
    endcase
  end

  // one read at a time, answer the cycle after the address
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rdMux;
        s_axi_rresp   <= rdHit ? 2'b00 : 2'b10;
        s_axi_arready <= 1'b0;
      end else if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencer decisions
  // ----------------------------------------------------------------
  logic wrStart1;   // software writes start = 1
  logic wrStart0;   // software writes start = 0
  logic trigOk;     // trigger is accepted now
  logic scanEnd;    // last slot result arrives
  logic restart;    // scan restarts at slot zero
  logic doneNow;    // a result is stored this cycle

  assign wrStart1 = wrMode && wData[`ASQ_BIT_START];
  assign wrStart0 = wrMode && !wData[`ASQ_BIT_START];
  assign trigOk   = hwTrigger && powerEnable
                    && (waitMode || startBit)
                    && state != ST_STOP;
  assign doneNow  = state == ST_CONV && convRsp.done && !restart
                    && !wrStart0;
  assign scanEnd  = doneNow && slot == 2'd3;
  assign restart  = state == ST_CONV
                    && (trigOk || wrChsel || wrStart1);

  // ----------------------------------------------------------------
  // mode register bits
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      powerEnable <= 1'b0;
      waitMode    <= 1'b0;
    end else if (wrMode) begin
      powerEnable <= wData[`ASQ_BIT_POWER];
      waitMode    <= wData[`ASQ_BIT_WAIT];
    end
  end

  // start bit: hardware set wins over a software clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      startBit <= 1'b0;
    end else if (waitMode && state == ST_STANDBY && trigOk) begin
      startBit <= 1'b1;
    end else if (waitMode && scanEnd) begin
      startBit <= 1'b0;
    end else if (wrMode) begin
      startBit <= wData[`ASQ_BIT_START];
    end
  end

  logic [31:0] selWord;  // channel select with this cycle's write merged

  // byte lanes of a channel-select write merged over the old value,
  // so a restart picks its first channel from the new selection
  always_comb begin
    selWord = chanSel;
    for (int b = 0; b < 4; b++) begin
      if (wrChsel && wStrb[b]) begin
        selWord[b*8 +: 8] = wData[b*8 +: 8];
      end
    end
  end

  // channel select, byte-lane writes
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      chanSel <= `ASQ_CHSEL_RST;
    end else if (wrChsel) begin
      chanSel <= selWord;
    end
  end

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_STOP;
      slot  <= 2'd0;
    end else begin
      case (state)
        ST_STOP: begin
          if (powerEnable) begin
            state <= ST_STANDBY;
          end
        end
        ST_STANDBY: begin
          slot <= 2'd0;
          if (!powerEnable) begin
            state <= ST_STOP;
          end else if (trigOk) begin
            state <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (restart) begin
            slot <= 2'd0;
          end else if (wrStart0) begin
            state <= ST_STANDBY;
            slot  <= 2'd0;
          end else if (scanEnd) begin
            state <= ST_STANDBY;
            slot  <= 2'd0;
          end else if (doneNow) begin
            slot <= slot + 2'd1;
          end
        end
        default: begin
          state <= ST_STOP;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // converter requests
  // ----------------------------------------------------------------
  logic [1:0] nextSlot;  // slot the next request converts

  assign nextSlot = (restart || state != ST_CONV) ? 2'd0
                    : slot + 2'd1;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      convReq <= '0;
    end else begin
      convReq.start   <= (state == ST_STANDBY && powerEnable && trigOk)
                         || restart || (doneNow && !scanEnd);
      convReq.abort   <= restart || (state == ST_CONV && wrStart0);
      convReq.channel <= selWord[nextSlot*`ASQ_SLOT_W +: `ASQ_CH_W];
    end
  end

  // converter power: wait mode powers only during a scan
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      converterPowered <= 1'b0;
    end else begin
      converterPowered <= powerEnable
                          && (!waitMode
                              || (state == ST_CONV && !scanEnd
                                  && !wrStart0)
                              || (state == ST_STANDBY && trigOk));
    end
  end

  // ----------------------------------------------------------------
  // results and interrupts
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      result  <= '0;
      resChan <= '0;
    end else if (doneNow) begin
      result  <= convRsp.data;
      resChan <= chanSel[slot*`ASQ_SLOT_W +: `ASQ_CH_W];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      conversionDoneIrq <= 1'b0;
    end else begin
      conversionDoneIrq <= doneNow;
    end
  end

  // sticky status, write one to clear, set wins
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqStat <= 1'b0;
    end else if (doneNow) begin
      irqStat <= 1'b1;
    end else if (wrIrqSt && wData[`ASQ_BIT_EOC]) begin
      irqStat <= 1'b0;
    end
  end

  // mask register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqMask <= 1'b0;
    end else if (wrIrqMk) begin
      irqMask <= wData[`ASQ_BIT_EOC];
    end
  end

  // level interrupt output
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= (irqStat || doneNow) && irqMask;
    end
  end

endmodule : asq_seq

// >>> include/asq_consts.svh
/*
  register offsets, field positions and reset values of the
  hardware-trigger scan sequencer.
  assumes: included by the package and the design file by bare name.
*/
`ifndef ASQ_CONSTS_SVH
`define ASQ_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ASQ_OFS_MODE   8'h00
`define ASQ_OFS_CHSEL  8'h04
`define ASQ_OFS_RESULT 8'h08
`define ASQ_OFS_STATUS 8'h0C
`define ASQ_OFS_IRQST  8'h10
`define ASQ_OFS_IRQMSK 8'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ASQ_BIT_POWER  0
`define ASQ_BIT_START  1
`define ASQ_BIT_WAIT   2
`define ASQ_BIT_EOC    0
`define ASQ_CH_W       5
`define ASQ_SLOT_W     8
`define ASQ_RES_W      10
`define ASQ_RES_CH_LSB 16

// ----------------------------------------------------------------
// reset values and misc
// ----------------------------------------------------------------
`define ASQ_CHSEL_RST  32'h03020100
`define ASQ_SLOTS      4
`define ASQ_ADDR_W     8
`define ASQ_STAB_NS    1000
`define ASQ_CLK_MHZ    50
`define ASQ_STAB_CYC   ((`ASQ_STAB_NS * `ASQ_CLK_MHZ + 999) / 1000)

`endif

// >>> include/asq_pkg.sv
/*
  types shared by the scan sequencer and its surroundings.
  assumes: asq_consts.svh is on the include path.
*/
`include "asq_consts.svh"

package asq_pkg;

  // ----------------------------------------------------------------
  // converter request and answer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                   start;    // begin one conversion
    logic                   abort;    // drop conversion in flight
    logic [`ASQ_CH_W-1:0]   channel;  // analog input to convert
  } asq_conv_req_s;

  typedef struct packed {
    logic                   done;     // conversion finished
    logic [`ASQ_RES_W-1:0]  data;     // its result
  } asq_conv_rsp_s;

  // sequencer states
  typedef enum logic [1:0] {
    ST_STOP,
    ST_STANDBY,
    ST_CONV
  } asq_state_e;

endpackage : asq_pkg

// >>> sim/asq_seq_asserts.sv
/*
  concurrent checks on the scan sequencer's ports, bound to asq_seq.
  assumes: one clock core_clk, async active-low reset arst_n.
*/
`timescale 1ns/100ps

module asq_seq_asserts (
  input wire logic                   core_clk,
  input wire logic                   arst_n,
  input wire logic                   s_axi_wvalid,
  input wire logic                   s_axi_wready,
  input wire logic                   s_axi_bvalid,
  input wire logic                   s_axi_bready,
  input wire logic                   s_axi_arready,
  input wire logic [31:0]            s_axi_rdata,
  input wire logic                   s_axi_rvalid,
  input wire logic                   s_axi_rready,
  input wire logic                   hwTrigger,
  input wire asq_pkg::asq_conv_req_s convReq,
  input wire asq_pkg::asq_conv_rsp_s convRsp,
  input wire logic                   converterPowered,
  input wire logic                   conversionDoneIrq,
  input wire logic                   irq
);
  import asq_pkg::*;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  logic [2:0] causeAge;  // cycles left in which a start may follow a cause
  logic       busy;      // a conversion is in flight

  // age of the latest trigger, result or register write
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      causeAge <= 3'h0;
    end else if (hwTrigger || convRsp.done
                 || (s_axi_wvalid && s_axi_wready)) begin
      causeAge <= 3'h6;
    end else if (causeAge != 3'h0) begin
      causeAge <= causeAge - 3'h1;
    end
  end

  // in flight from a start until its answer or a bare abort
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
    end else if (convReq.start) begin
      busy <= 1'b1;
    end else if (convReq.abort || convRsp.done) begin
      busy <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_done_pulse: assert property (
    conversionDoneIrq |=> !conversionDoneIrq)
    else $error("done interrupt longer than one cycle");
  a_irq_from_done: assert property (
    conversionDoneIrq |-> $past(convRsp.done))
    else $error("done interrupt without converter answer");
  a_start_power: assert property (
    convReq.start |-> ##[0:1] converterPowered)
    else $error("conversion started while converter unpowered");
  a_start_cause: assert property (
    convReq.start |-> causeAge != 3'h0)
    else $error("conversion started without trigger or write");
  // a bare abort ends the scan one cycle before busy drops
  a_trig_restart: assert property (
    hwTrigger && busy && !(convReq.abort && !convReq.start)
    |-> ##[1:2] (convReq.start && convReq.abort))
    else $error("trigger during scan did not restart it");
  a_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rvalid_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");

  c_done: cover property (conversionDoneIrq);
  c_restart: cover property (convReq.start && convReq.abort);
  c_irq: cover property (irq);
endmodule : asq_seq_asserts

bind asq_seq asq_seq_asserts u_asserts (
  .core_clk(core_clk), .arst_n(arst_n), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .hwTrigger(hwTrigger), .convReq(convReq),
  .convRsp(convRsp), .converterPowered(converterPowered),
  .conversionDoneIrq(conversionDoneIrq), .irq(irq)
);

// >>> sim/asq_conv_model.sv
/*
  behavioural analog converter: answers each start that is not aborted after a set latency.
  assumes: requests are synchronous to core_clk; latency is at least 1.
*/
`timescale 1ns/100ps
`include "asq_consts.svh"

module asq_conv_model (
  input  wire logic                   core_clk,
  input  wire logic                   arst_n,
  input  wire asq_pkg::asq_conv_req_s convReq,
  input  wire logic [7:0]             latency,
  output asq_pkg::asq_conv_rsp_s      convRsp
);
  import asq_pkg::*;

  logic [7:0]            remain;    // cycles to the answer, 0 idle
  logic [`ASQ_CH_W-1:0]  chan;      // channel being converted
  logic [`ASQ_RES_W-1:0] lastData;  // last result driven

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      remain <= 8'h00;
      chan   <= '0;
    end else if (convReq.start) begin
      remain <= latency;
      chan   <= convReq.channel;
    end else if (convReq.abort) begin
      remain <= 8'h00;
    end else if (remain != 8'h00) begin
      remain <= remain - 8'h01;
    end
  end

  // keep last result so idle data can differ from it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) lastData <= '0;
    else if (convRsp.done) lastData <= convRsp.data;
  end

  // result pattern names its channel; idle data is scrambled
  assign convRsp.done = (remain == 8'h01);
  assign convRsp.data = convRsp.done ? {5'h15, chan} : ~lastData;
endmodule : asq_conv_model

// >>> sim/asq_seq_tb.sv
/*
  register-level testbench of the scan sequencer with converter model.
  assumes: asq_pkg, asq_seq, asq_conv_model and the checker compiled.
*/
`timescale 1ns/100ps
`include "asq_consts.svh"

module asq_seq_tb;
  import asq_pkg::*;

  logic core_clk = 1'b0, arst_n = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, latency = 8'h02;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, hwTrigger = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, converterPowered, conversionDoneIrq, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  asq_conv_req_s convReq;
  asq_conv_rsp_s convRsp;
  int error_cnt = 0, samples_checked = 0;
  int doneCnt = 0, startCnt = 0, abortCnt = 0;
  logic [31:0] chanLog = '0;  // channels of starts, newest lowest

  always #10 core_clk = ~core_clk;

  asq_seq uut (.core_clk(core_clk), .arst_n(arst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .hwTrigger(hwTrigger), .convReq(convReq),
    .convRsp(convRsp), .converterPowered(converterPowered),
    .conversionDoneIrq(conversionDoneIrq), .irq(irq));

  asq_conv_model u_conv (.core_clk(core_clk), .arst_n(arst_n),
    .convReq(convReq), .latency(latency), .convRsp(convRsp));

  // count starts, aborts and stored results
  always @(posedge core_clk) begin
    if (convReq.start) begin
      startCnt++;
      chanLog = {chanLog[26:0], convReq.channel};
    end
    if (convReq.abort) abortCnt++;
    if (conversionDoneIrq) doneCnt++;
  end

  task automatic chk(input string name, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask : chk

  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 100);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 100) chk("write timeout", 0, 1);
  endtask : axiWrite

  task automatic rd(input logic [7:0] a, input string name,
                    input logic [31:0] exp);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 100);
    rd_d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 100) chk("read timeout", 0, 1);
    chk(name, exp, rd_d);
    // let rready settle low before another read raises it
    @(posedge core_clk);
  endtask : rd

  // one-cycle trigger pulse; counters are cleared separately by clr
  task automatic trig;
    hwTrigger <= 1'b1;
    @(posedge core_clk);
    hwTrigger <= 1'b0;
  endtask : trig

  task automatic clr;
    doneCnt = 0;
    startCnt = 0;
    abortCnt = 0;
    chanLog = '0;
  endtask : clr

  task automatic waitDones(input int n);
    int k;
    k = 0;
    while (doneCnt < n && k < 300) begin
      @(posedge core_clk);
      k++;
    end
    repeat (3) @(posedge core_clk);
  endtask : waitDones

  task end_of_test;
    $display("error_cnt %0d samples_checked %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    end_of_test;
  end

  initial begin
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    rd(`ASQ_OFS_CHSEL, "chsel reset", `ASQ_CHSEL_RST);
    rd(`ASQ_OFS_MODE, "mode reset", 32'h0);
    rd(8'h18, "unmapped read", 32'h0);
    chk("unmapped rresp", 2'h2, rsp);
    axiWrite(`ASQ_OFS_MODE, 32'h1);
    rd(`ASQ_OFS_STATUS, "standby", 32'h101);
    clr;
    trig;
    repeat (10) @(posedge core_clk);
    chk("ignored while start 0", 0, startCnt);
    repeat (`ASQ_STAB_CYC) @(posedge core_clk); // settle first
    axiWrite(`ASQ_OFS_MODE, 32'h3);
    repeat (10) @(posedge core_clk);
    chk("armed only", 0, startCnt);
    trig;
    waitDones(4);
    chk("scan order", {5'd0, 5'd1, 5'd2, 5'd3}, chanLog);
    chk("results", 4, doneCnt);
    rd(`ASQ_OFS_RESULT, "last result", 32'h000302A3);
    rd(`ASQ_OFS_MODE, "start kept", 32'h3);
    chk("irq masked", 0, irq);
    axiWrite(`ASQ_OFS_IRQMSK, 32'h1);
    repeat (2) @(posedge core_clk);
    chk("irq unmasked", 1, irq);
    axiWrite(`ASQ_OFS_IRQST, 32'h1);
    repeat (2) @(posedge core_clk);
    chk("irq cleared", 0, irq);
    latency <= 8'd10;
    clr;
    trig;
    repeat (4) @(posedge core_clk);
    trig;
    waitDones(4);
    chk("trigger restart", 5, startCnt);
    chk("trigger abort", 1, abortCnt);
    clr;
    trig;
    repeat (3) @(posedge core_clk);
    axiWrite(`ASQ_OFS_CHSEL, 32'h07060504);
    waitDones(4);
    chk("new selection", {5'd0, 5'd4, 5'd5, 5'd6, 5'd7}, chanLog);
    chk("new sel results", 4, doneCnt);
    clr;
    trig;
    repeat (3) @(posedge core_clk);
    axiWrite(`ASQ_OFS_MODE, 32'h3);
    waitDones(4);
    chk("start rewrite", 5, startCnt);
    clr;
    trig;
    repeat (3) @(posedge core_clk);
    axiWrite(`ASQ_OFS_MODE, 32'h1);
    repeat (20) @(posedge core_clk);
    chk("start clear abort", 0, doneCnt);
    rd(`ASQ_OFS_STATUS, "still powered", 32'h101);
    axiWrite(`ASQ_OFS_MODE, 32'h0);
    rd(`ASQ_OFS_STATUS, "stopped", 32'h0);
    axiWrite(`ASQ_OFS_MODE, 32'h4);
    clr;
    trig;
    repeat (10) @(posedge core_clk);
    chk("wait unpowered", 0, startCnt);
    axiWrite(`ASQ_OFS_MODE, 32'h5);
    trig;
    repeat (3) @(posedge core_clk);
    rd(`ASQ_OFS_MODE, "start set by trigger", 32'h7);
    waitDones(4);
    rd(`ASQ_OFS_MODE, "start cleared", 32'h5);
    chk("converter off", 0, converterPowered);
    clr;
    trig;
    repeat (3) @(posedge core_clk);
    axiWrite(`ASQ_OFS_MODE, 32'h5);
    repeat (20) @(posedge core_clk);
    chk("wait abort", 0, doneCnt);
    chk("wait abort off", 0, converterPowered);
    axiWrite(8'h1C, 32'h1);
    chk("unmapped bresp", 2'h2, rsp);
    end_of_test;
  end
endmodule : asq_seq_tb
